/* File: logic/compact_timer_core.sv */
`timescale 1ns/1ps
module compact_timer_core
  import compact_timer_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_HIGH_CLK_TICK,
  input wire logic I_SUB_CLK,
  input wire logic I_EXT_CLOCK_PIN,
  output logic O_TIMER_OUTPUT_PIN,
  output logic O_CMP_A_IRQ,
  output logic O_CMP_P_IRQ
);

  typedef struct packed {
    logic count_pause;
    clock_select_type clock_select;
    logic timer_on;
    op_mode_type op_mode_select;
    logic [1:0] pin_action_select;
    logic output_initial_level;
    logic output_polarity;
    logic duty_period_swap;
    logic clear_source_select;
    logic [15:0] count;
    logic [15:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic [7:0] low_buffer;
    logic [5:0] div_sys;
    logic [5:0] div_high;
    logic out_level;
    logic pin;
    logic irq_a;
    logic irq_p;
    logic [7:0] rdata;
  } core_state_type;

  core_state_type s_q;
  core_state_type s_d;

  logic pin_rise;
  logic pin_fall;
  logic sub_rise;

  ////////////////////////////////////////////////////////////////
  // asynchronous sources: external pin and sub clock
  edge_sync u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .i_async(I_EXT_CLOCK_PIN),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  edge_sync u_sub_sync (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .i_async(I_SUB_CLK),
    .o_rise(sub_rise),
    .o_fall()
  );

  ////////////////////////////////////////////////////////////////
  // next-state logic
  logic tick;
  logic sys4_tick;
  logic high16_tick;
  logic high64_tick;
  logic [16:0] next_count;
  logic [16:0] a_target;
  logic [16:0] p_target;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clear_now;
  logic [16:0] pwm_period;
  logic [16:0] pwm_duty;
  logic pwm_active;
  logic on_rise;
  logic [7:0] ctrl0_new;
  logic [7:0] ctrl0_read;
  logic [7:0] ctrl1_read;

  always_comb begin
    s_d = s_q;
    s_d.irq_a = 1'b0;
    s_d.irq_p = 1'b0;
    s_d.rdata = RST_BYTE;
    ctrl0_new = I_WDATA;
    on_rise = 1'b0;

    // prescalers free-run so the selected rate is steady
    s_d.div_sys = (s_q.div_sys == DIV_SYS_4_LAST) ? 6'h00 : s_q.div_sys + 6'h01;
    sys4_tick = (s_q.div_sys == DIV_SYS_4_LAST);
    high16_tick = I_HIGH_CLK_TICK && (s_q.div_high[3:0] == DIV_HIGH_16_LAST[3:0]);
    high64_tick = I_HIGH_CLK_TICK && (s_q.div_high == DIV_HIGH_64_LAST);
    if (I_HIGH_CLK_TICK) begin
      s_d.div_high = s_q.div_high + 6'h01;
    end

    // counter clock source choice
    unique case (s_q.clock_select)
      CLK_SYS_DIV4: tick = sys4_tick;
      CLK_SYS: tick = 1'b1;
      CLK_HIGH_DIV16: tick = high16_tick;
      CLK_HIGH_DIV64: tick = high64_tick;
      CLK_SUB_A, CLK_SUB_B: tick = sub_rise;
      CLK_PIN_RISE: tick = pin_rise;
      CLK_PIN_FALL: tick = pin_fall;
    endcase

    // comparisons look at the value the tick would produce
    next_count = {1'b0, s_q.count} + 17'h00001;
    overflow = next_count[16];
    // a zero compare-A value matches at the wrap
    a_target = {(s_q.compare_a_value == RST_WORD), s_q.compare_a_value};
    // period zero lands on 65536, otherwise value times 256
    p_target = {(s_q.compare_p_value == RST_BYTE), s_q.compare_p_value, 8'h00};
    match_a = (next_count == a_target);
    match_p = (next_count == p_target);

    // pwm duty/period roles, swappable
    if (s_q.duty_period_swap) begin
      pwm_period = a_target;
      pwm_duty = {1'b0, s_q.compare_p_value, 8'h00};
    end else begin
      pwm_period = p_target;
      pwm_duty = {1'b0, s_q.compare_a_value};
    end

    // clearing event: pwm ends on its period, else chosen source
    if (s_q.op_mode_select == MODE_PWM) begin
      clear_now = (next_count == pwm_period) || overflow;
    end else if (s_q.clear_source_select) begin
      clear_now = match_a || overflow;
    end else begin
      clear_now = match_p || overflow;
    end

    // counting: on, not paused, selected clock ticking
    if (s_q.timer_on && !s_q.count_pause && tick) begin
      s_d.count = clear_now ? RST_WORD : next_count[15:0];
      s_d.irq_a = match_a;
      s_d.irq_p = match_p;
      if (s_q.op_mode_select == MODE_COMPARE_OUT && match_a) begin
        unique case (s_q.pin_action_select)
          ACT_NONE: s_d.out_level = s_q.out_level;
          ACT_LOW: s_d.out_level = 1'b0;
          ACT_HIGH: s_d.out_level = 1'b1;
          ACT_TOGGLE: s_d.out_level = ~s_q.out_level;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////
    // register writes
    if (I_WR) begin
      unique case (I_ADDR)
        OFS_CTRL_CLOCK_ON: begin
          s_d.count_pause = ctrl0_new[POS_COUNT_PAUSE];
          s_d.clock_select = clock_select_type'(ctrl0_new[POS_CLOCK_SELECT +: 3]);
          s_d.timer_on = ctrl0_new[POS_TIMER_ON];
          on_rise = ctrl0_new[POS_TIMER_ON] && !s_q.timer_on;
        end
        OFS_CTRL_MODE_OUTPUT: begin
          s_d.op_mode_select = op_mode_type'(I_WDATA[POS_OP_MODE_SELECT +: 2]);
          s_d.pin_action_select = I_WDATA[POS_PIN_ACTION_SELECT +: 2];
          s_d.output_initial_level = I_WDATA[POS_OUTPUT_INITIAL_LEVEL];
          s_d.output_polarity = I_WDATA[POS_OUTPUT_POLARITY];
          s_d.duty_period_swap = I_WDATA[POS_DUTY_PERIOD_SWAP];
          s_d.clear_source_select = I_WDATA[POS_CLEAR_SOURCE_SELECT];
        end
        OFS_COMPARE_A_LOW: begin
          s_d.low_buffer = I_WDATA;
        end
        OFS_COMPARE_A_HIGH: begin
          s_d.compare_a_value = {I_WDATA, s_q.low_buffer};
        end
        OFS_COMPARE_P_PERIOD: begin
          s_d.compare_p_value = I_WDATA;
        end
        default: begin
          // counter bytes and unmapped offsets ignore writes
          s_d.count_pause = s_q.count_pause;
        end
      endcase
    end

    // timer-on rising edge: only software path to the count
    if (on_rise) begin
      s_d.count = RST_WORD;
      s_d.out_level = s_q.output_initial_level;
    end

    ////////////////////////////////////////////////////////////////
    // register reads, data valid the cycle after the strobe
    ctrl0_read = {s_q.count_pause, s_q.clock_select, s_q.timer_on, 3'h0};
    ctrl1_read = {s_q.op_mode_select, s_q.pin_action_select, s_q.output_initial_level,
                  s_q.output_polarity, s_q.duty_period_swap, s_q.clear_source_select};
    if (I_RD) begin
      unique case (I_ADDR)
        OFS_CTRL_CLOCK_ON: s_d.rdata = ctrl0_read;
        OFS_CTRL_MODE_OUTPUT: s_d.rdata = ctrl1_read;
        OFS_COUNT_LOW: s_d.rdata = s_q.low_buffer;
        OFS_COUNT_HIGH: begin
          s_d.rdata = s_q.count[15:8];
          s_d.low_buffer = s_q.count[7:0];
        end
        OFS_COMPARE_A_LOW: s_d.rdata = s_q.low_buffer;
        OFS_COMPARE_A_HIGH: begin
          s_d.rdata = s_q.compare_a_value[15:8];
          s_d.low_buffer = s_q.compare_a_value[7:0];
        end
        OFS_COMPARE_P_PERIOD: s_d.rdata = s_q.compare_p_value;
        default: s_d.rdata = RST_BYTE;
      endcase
    end

    ////////////////////////////////////////////////////////////////
    // pin shaping: pwm active while below duty, polarity last
    pwm_active = ({1'b0, s_q.count} < pwm_duty);
    unique case (s_q.op_mode_select)
      MODE_COMPARE_OUT: s_d.pin = s_q.out_level ^ s_q.output_polarity;
      MODE_PWM: begin
        // initial-level bit doubles as pwm active level
        if (s_q.pin_action_select == PWM_WAVE) begin
          s_d.pin = ~(pwm_active ^ s_q.output_initial_level) ^ s_q.output_polarity;
        end else if (s_q.pin_action_select == PWM_FORCE_ACTIVE) begin
          s_d.pin = s_q.output_initial_level ^ s_q.output_polarity;
        end else begin
          s_d.pin = ~s_q.output_initial_level ^ s_q.output_polarity;
        end
      end
      // undefined pin state in timer mode, held low here
      MODE_TIMER, MODE_UNDEFINED: s_d.pin = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign O_RDATA = s_q.rdata;
  assign O_TIMER_OUTPUT_PIN = s_q.pin;
  assign O_CMP_A_IRQ = s_q.irq_a;
  assign O_CMP_P_IRQ = s_q.irq_p;

endmodule : compact_timer_core

/* File: logic/compact_timer_pkg.sv */
package compact_timer_pkg;

  // register offsets on the byte port
  localparam logic [2:0] OFS_CTRL_CLOCK_ON = 3'h0;
  localparam logic [2:0] OFS_CTRL_MODE_OUTPUT = 3'h1;
  localparam logic [2:0] OFS_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFS_COMPARE_A_LOW = 3'h4;
  localparam logic [2:0] OFS_COMPARE_A_HIGH = 3'h5;
  localparam logic [2:0] OFS_COMPARE_P_PERIOD = 3'h6;

  // first control register fields
  localparam int POS_COUNT_PAUSE = 7;
  localparam int POS_CLOCK_SELECT = 4;
  localparam int POS_TIMER_ON = 3;

  // second control register fields
  localparam int POS_OP_MODE_SELECT = 6;
  localparam int POS_PIN_ACTION_SELECT = 4;
  localparam int POS_OUTPUT_INITIAL_LEVEL = 3;
  localparam int POS_OUTPUT_POLARITY = 2;
  localparam int POS_DUTY_PERIOD_SWAP = 1;
  localparam int POS_CLEAR_SOURCE_SELECT = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // prescaler divide counts, as counter terminal values
  localparam logic [5:0] DIV_SYS_4_LAST = 6'h03;
  localparam logic [5:0] DIV_HIGH_16_LAST = 6'h0f;
  localparam logic [5:0] DIV_HIGH_64_LAST = 6'h3f;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_SYS = 3'h1,
    CLK_HIGH_DIV16 = 3'h2,
    CLK_HIGH_DIV64 = 3'h3,
    CLK_SUB_A = 3'h4,
    CLK_SUB_B = 3'h5,
    CLK_PIN_RISE = 3'h6,
    CLK_PIN_FALL = 3'h7
  } clock_select_type;

  typedef enum logic [1:0] {
    MODE_COMPARE_OUT = 2'h0,
    MODE_UNDEFINED = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } op_mode_type;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } pin_action_type;

  // pwm meaning of the pin action field
  localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;

endpackage : compact_timer_pkg

/* File: logic/edge_sync.sv */
`timescale 1ns/1ps
module edge_sync (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } edge_state_type;

  edge_state_type s_q;
  edge_state_type s_d;

  ////////////////////////////////////////////////////////////////
  // two-stage synchroniser, edge taken only from the second stage
  always_comb begin
    s_d = s_q;
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // one-cycle pulses per detected edge
  assign o_rise = s_q.sync & ~s_q.prev;
  assign o_fall = ~s_q.sync & s_q.prev;

endmodule : edge_sync

/* File: tb/compact_timer_properties.sv */
`timescale 1ns/1ps
module compact_timer_properties
  import compact_timer_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic O_TIMER_OUTPUT_PIN,
  input wire logic O_CMP_A_IRQ,
  input wire logic O_CMP_P_IRQ
);
  logic [7:0] c0_q, c1_q, rp_q, buf_q;
  logic [15:0] ca_q;
  logic bv_q, cv_q;
  wire run = c0_q[POS_TIMER_ON];
  wire tmode = c1_q[POS_OP_MODE_SELECT +: 2] == MODE_TIMER;
  // shadow of what software wrote; the low buffer is unknown after a count read
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      {c0_q, c1_q, rp_q, buf_q, ca_q} <= '0;
      {bv_q, cv_q} <= 2'h3;
    end else if (I_WR) begin
      case (I_ADDR)
        OFS_CTRL_CLOCK_ON: c0_q <= I_WDATA;
        OFS_CTRL_MODE_OUTPUT: c1_q <= I_WDATA;
        OFS_COMPARE_P_PERIOD: rp_q <= I_WDATA;
        OFS_COMPARE_A_LOW: {buf_q, bv_q} <= {I_WDATA, 1'b1};
        OFS_COMPARE_A_HIGH: {ca_q, cv_q} <= {I_WDATA, buf_q, bv_q};
        default: ;
      endcase
    end else if (I_RD && I_ADDR == OFS_COMPARE_A_HIGH) begin
      {buf_q, bv_q} <= {ca_q[7:0], cv_q};
    end else if (I_RD && I_ADDR == OFS_COUNT_HIGH) begin
      bv_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  chk_ctrl0_low_zero: assert property (
    $past(I_RD && I_ADDR == OFS_CTRL_CLOCK_ON) |-> O_RDATA == {$past(c0_q[7:3]), 3'h0}) else $error("ctrl0 readback");
  chk_period_read: assert property (
    $past(I_RD && I_ADDR == OFS_COMPARE_P_PERIOD) |-> O_RDATA == $past(rp_q)) else $error("period readback");
  chk_cmpa_high_read: assert property (
    $past(I_RD && I_ADDR == OFS_COMPARE_A_HIGH) |-> O_RDATA == $past(ca_q[15:8])) else $error("compare high");
  chk_low_buffer_read: assert property (
    $past(I_RD && (I_ADDR == OFS_COUNT_LOW || I_ADDR == OFS_COMPARE_A_LOW) && bv_q) |-> O_RDATA == $past(buf_q))
    else $error("low buffer");
  chk_off_quiet: assert property (
    (!run) [*3] |-> !O_CMP_A_IRQ && !O_CMP_P_IRQ) else $error("match while off");
  chk_pause_quiet: assert property (
    c0_q[POS_COUNT_PAUSE] && $past(c0_q[POS_COUNT_PAUSE]) && $past(c0_q[POS_COUNT_PAUSE], 2)
    |-> !O_CMP_A_IRQ && !O_CMP_P_IRQ) else $error("match while paused");
  chk_timer_mode_pin: assert property (
    tmode [*4] |-> !O_TIMER_OUTPUT_PIN) else $error("pin in timer mode");
  chk_on_rise_pin: assert property (
    $rose(run) && c1_q[7:6] == MODE_COMPARE_OUT |-> ##[1:2] O_TIMER_OUTPUT_PIN == (c1_q[3] ^ c1_q[2]))
    else $error("initial level");
  cover property ($rose(O_CMP_P_IRQ));
  cover property ($rose(O_CMP_A_IRQ) && run);
  cover property ($rose(O_TIMER_OUTPUT_PIN));
endmodule : compact_timer_properties

bind compact_timer_core compact_timer_properties u_props (.I_CORE_CLK, .I_ARST_N, .I_ADDR, .I_WDATA, .I_WR,
  .I_RD, .O_RDATA, .O_TIMER_OUTPUT_PIN, .O_CMP_A_IRQ, .O_CMP_P_IRQ);

/* File: tb/ext_pin_model.sv */
`timescale 1ns/1ps
module ext_pin_model (
  input wire logic i_clk,
  input wire logic i_en,
  output logic o_pin,
  output logic o_sub,
  output int o_rises,
  output int o_falls
);
  logic pin = 1'b0;
  logic sub = 1'b0;
  int ph = 0;
  int nr = 0;
  int nf = 0;
  assign {o_pin, o_sub} = {pin, sub};
  assign {o_rises, o_falls} = {nr, nf};
  // bursts end low so the pin stands still between them
  always @(posedge i_clk) begin
    ph <= (ph == 4) ? 0 : ph + 1;
    if (ph == 4 && (i_en || pin)) begin
      pin <= !pin;
      if (pin) nf <= nf + 1;
      else nr <= nr + 1;
    end
  end
  // sub clock runs free, ten core cycles a period
  always @(posedge i_clk) if (ph == 4) sub <= !sub;
endmodule : ext_pin_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import compact_timer_pkg::*;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
  logic clk, rst_n, wr, rd, en, pin, tpin, sub, irq_a, irq_p;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [15:0] c, c2;
  int errors = 0, comparisons = 0, cyc = 0, n, r0, rises, falls;
  // write offset, data, read offset, expected byte
  localparam logic [21:0] ROWS [8] = '{{3'h0, 8'hff, 3'h0, 8'hf8}, {3'h1, 8'hc8, 3'h1, 8'hc8},
    {3'h6, 8'h12, 3'h6, 8'h12}, {3'h4, 8'h34, 3'h4, 8'h34}, {3'h5, 8'h56, 3'h5, 8'h56},
    {3'h3, 8'hff, 3'h4, 8'h34}, {3'h7, 8'hff, 3'h7, 8'h00}, {3'h1, 8'h00, 3'h1, 8'h00}};
  localparam int EXP_CNT [6] = '{64, 256, 16, 4, 25, 25};
  compact_timer_core u_dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_HIGH_CLK_TICK(1'b1), .I_SUB_CLK(sub), .I_EXT_CLOCK_PIN(pin),
    .O_TIMER_OUTPUT_PIN(tpin), .O_CMP_A_IRQ(irq_a), .O_CMP_P_IRQ(irq_p));
  ext_pin_model u_far (.i_clk(clk), .i_en(en), .o_pin(pin), .o_sub(sub), .o_rises(rises), .o_falls(falls));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // high byte first so the low byte comes from the same snapshot
  task automatic rd_cnt(output logic [15:0] w);
    rd_reg(OFS_COUNT_HIGH, w[15:8]);
    rd_reg(OFS_COUNT_LOW, w[7:0]);
  endtask : rd_cnt
  task automatic wait_irq(input logic s, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while ((s ? irq_a : irq_p) !== 1'b1 && k < 2000);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, wr, rd, en, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr_reg(ROWS[i][21:19], ROWS[i][18:11]);
      rd_reg(ROWS[i][10:8], v);
      `CHK("reg_row", ROWS[i][7:0], v)
    end
    $display("rows done");
    // mid-run reset returns every register to zero
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      rd_reg(3'(a), v);
      `CHK("reset_val", 8'h00, v)
    end
    $display("reset done");
    // period 1 on the core clock: match every 256 counts
    wr_reg(OFS_COMPARE_P_PERIOD, 8'h01);
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h18);
    wait_irq(1'b0, n);
    `CHK("p_first", 256, n)
    wait_irq(1'b0, n);
    `CHK("p_gap", 256, n)
    $display("period done");
    // compare A at 16 clears the count and drives the pin by action code
    wr_reg(OFS_COMPARE_A_LOW, 8'h10);
    wr_reg(OFS_COMPARE_A_HIGH, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr_reg(OFS_CTRL_CLOCK_ON, 8'h10);
      wr_reg(OFS_CTRL_MODE_OUTPUT, {2'h0, 2'(m), (m < 2), 3'h1});
      wr_reg(OFS_CTRL_CLOCK_ON, 8'h18);
      repeat (3) @(posedge clk);
      `CHK("pin_init", (m < 2), tpin)
      wait_irq(1'b1, n);
      repeat (2) @(posedge clk);
      `CHK("pin_act", (m != 1), tpin)
    end
    wait_irq(1'b1, n);
    `CHK("a_gap", 14, n)
    $display("compare done");
    // pause and off freeze the count, the on edge zeroes it
    wr_reg(OFS_CTRL_MODE_OUTPUT, 8'h00);
    wr_reg(OFS_COMPARE_P_PERIOD, 8'h00);
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h98);
    rd_cnt(c);
    repeat (20) @(posedge clk);
    rd_cnt(c2);
    `CHK("pause_hold", c, c2)
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h18);
    repeat (20) @(posedge clk);
    rd_cnt(c2);
    `CHK("resume", 1'b1, c2 > c)
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h10);
    rd_cnt(c);
    repeat (20) @(posedge clk);
    rd_cnt(c2);
    `CHK("off_hold", c, c2)
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h18);
    rd_cnt(c);
    `CHK("on_zero", 1'b1, c < 16'h0008)
    $display("pause done");
    // every internal source over 256 core cycles
    for (int s = 0; s < 6; s++) begin
      wr_reg(OFS_CTRL_CLOCK_ON, 8'h00);
      wr_reg(OFS_CTRL_CLOCK_ON, {1'b0, 3'(s), 4'h8});
      repeat (254) @(posedge clk);
      rd_cnt(c);
      `CHK("sel_rate", 1'b1, (c + 2 >= EXP_CNT[s]) && (c <= EXP_CNT[s] + 2))
    end
    // external pin edges, rising then falling
    for (int s = 6; s < 8; s++) begin
      wr_reg(OFS_CTRL_CLOCK_ON, 8'h00);
      wr_reg(OFS_CTRL_CLOCK_ON, {1'b0, 3'(s), 4'h8});
      r0 = (s == 6) ? rises : falls;
      en <= 1'b1;
      repeat (100) @(posedge clk);
      en <= 1'b0;
      repeat (12) @(posedge clk);
      rd_cnt(c);
      `CHK("pin_edges", 16'((s == 6 ? rises : falls) - r0), c)
    end
    $display("clock select done");
    // pwm: period 256 counts, duty 64, active high, pin high below duty
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h00);
    wr_reg(OFS_CTRL_MODE_OUTPUT, 8'ha8);
    wr_reg(OFS_COMPARE_P_PERIOD, 8'h01);
    wr_reg(OFS_COMPARE_A_LOW, 8'h40);
    wr_reg(OFS_COMPARE_A_HIGH, 8'h00);
    wr_reg(OFS_CTRL_CLOCK_ON, 8'h18);
    repeat (10) @(posedge clk);
    #1 `CHK("pwm_active", 1'b1, tpin)
    repeat (100) @(posedge clk);
    #1 `CHK("pwm_inactive", 1'b0, tpin)
    repeat (200) @(posedge clk);
    #1 `CHK("pwm_next_period", 1'b1, tpin)
    $display("pwm done");
    complete_run();
  end
endmodule : tb
